// file: verilog/timing_reference_selector.v
// Operation
// - recover timing from DS-1C mode 2, DS-1 ESF/D4, or composite clock
// - watch framing and continuity; only good inputs may serve as source
// - composite clock bypasses recovery loop; DS-1/DS-1C go through it
// - on dual input loss enter configured holdover or free-run mode
// - holdover keeps oscillator at last good input frequency
// - restored input during holdover: relock and take timing from it
// - free-run uses factory reference on dual loss; violation density change fails composite input
// - composite input restored in free-run: drop factory reference, use input
// - automatic and manual reference changes cause no output discontinuity
// - recovery from holdover or free-run is hitless too
// - two dedicated output tap pairs, one per auxiliary panel
// - option switch 1: open DS-1C, closed DS-1
// - option switch 2: open ESF, closed D4 framing
// - option switch 3: open B8ZS coding, closed no B8ZS
// - option switch 4: open di-group B, closed di-group A
// - mode switch: holdover setting or free-run setting
// - restored input must stay good one second; corruption restarts wait
// - one shared selection state names input A or B as source
`timescale 1ns/1ps
`include "timing_sel_regs.vh"

module timing_reference_selector #(
    parameter REC_CYCLES = `REC_CYCLES,
    parameter LOS_CYCLES = `LOS_CYCLES,
    parameter DIV_RATIO  = `DIV_RATIO,
    parameter FREE_HALF  = `FREE_HALF_PERIOD
) (
    // clock and reset
    input  wire       REF_CLK,
    input  wire       RESET_N,
    // redundant reference inputs A and B
    input  wire       IN_A_CLK,
    input  wire       IN_B_CLK,
    input  wire       IN_A_FRAME_ERR,
    input  wire       IN_B_FRAME_ERR,
    input  wire       IN_A_BPV,
    input  wire       IN_B_BPV,
    // configuration switches
    input  wire [3:0] INPUT_OPTION_SWITCH,
    input  wire       FAILOVER_MODE_SWITCH,
    input  wire       COMPOSITE_CLOCK_INPUT,
    input  wire       TRANSFER_REQ_N,
    // line interface configuration
    output reg        LIU_DS1C,
    output reg        LIU_ESF,
    output reg        LIU_B8ZS,
    output reg        LIU_SECOND_DIGROUP,
    // dual-rail timing to distributor packs
    output reg        DR_POS,
    output reg        DR_NEG,
    // auxiliary panel taps
    output reg        AUX1_POS,
    output reg        AUX1_NEG,
    output reg        AUX2_POS,
    output reg        AUX2_NEG,
    // status to shelf alarm unit
    output reg        SOURCE_IS_B,
    output reg [1:0]  MODE_STATUS,
    output reg        ALARM_IN_FAIL_A,
    output reg        ALARM_IN_FAIL_B,
    output reg        ALARM_DUAL_FAIL
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_s1_q;
    reg rst_n;

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire [6:0] pin_raw = {TRANSFER_REQ_N, COMPOSITE_CLOCK_INPUT, FAILOVER_MODE_SWITCH,
                          IN_B_BPV, IN_A_BPV, IN_B_FRAME_ERR, IN_A_FRAME_ERR};
    reg  [6:0] pin_s1_q;
    reg  [6:0] pin_q;
    reg  [3:0] opt_s1_q;
    reg  [3:0] opt_q;
    reg  [1:0] bpv_d1_q;
    reg        xfer_d1_q;

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            // button idles high, so reset must not fake a press
            pin_s1_q  <= 7'h40;
            pin_q     <= 7'h40;
            opt_s1_q  <= 4'h0;
            opt_q     <= 4'h0;
            bpv_d1_q  <= 2'h0;
            xfer_d1_q <= 1'b1;
        end else begin
            pin_s1_q  <= pin_raw;
            pin_q     <= pin_s1_q;
            opt_s1_q  <= INPUT_OPTION_SWITCH;
            opt_q     <= opt_s1_q;
            bpv_d1_q  <= pin_q[3:2];
            xfer_d1_q <= pin_q[6];
        end
    end

    wire [1:0] frame_err    = pin_q[1:0];
    wire [1:0] bpv_p        = pin_q[3:2] & ~bpv_d1_q;
    wire       holdover_cfg = pin_q[4];
    wire       cc_mode      = pin_q[5];
    wire       xfer_p       = xfer_d1_q & ~pin_q[6];

    // ----------------------------------------
    // per-input monitoring and recognition
    // ----------------------------------------
    wire [1:0]        in_clk = {IN_B_CLK, IN_A_CLK};
    wire [1:0]        in_edge;
    wire [1:0]        in_active;
    wire [2*`PER_W-1:0] in_period;
    wire [1:0]        in_ok;
    wire [1:0]        good;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
            reg [`BPV_CNT_W-1:0] win_q;
            reg [`BPV_CNT_W-1:0] bpv_cnt_q;
            reg [`BPV_CNT_W-1:0] bpv_prev_q;
            reg                  shift_q;
            wire [`BPV_CNT_W-1:0] diff = (bpv_cnt_q > bpv_prev_q) ? bpv_cnt_q - bpv_prev_q
                                                                  : bpv_prev_q - bpv_cnt_q;

            edge_monitor #(
                .PER_W      (`PER_W),
                .LOS_CYCLES (LOS_CYCLES)
            ) u_mon (
                .clk     (REF_CLK),
                .rst_n   (rst_n),
                .link_in (in_clk[gi]),
                .edge_p  (in_edge[gi]),
                .active  (in_active[gi]),
                .period  (in_period[gi*`PER_W +: `PER_W])
            );

            // violation density per window, compared with the last window
            always @(posedge REF_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    win_q      <= {`BPV_CNT_W{1'b0}};
                    bpv_cnt_q  <= {`BPV_CNT_W{1'b0}};
                    bpv_prev_q <= {`BPV_CNT_W{1'b0}};
                    shift_q    <= 1'b0;
                end else begin
                    shift_q <= 1'b0;
                    // violation pulse leads the synced line edge by a cycle
                    if (bpv_p[gi]) begin
                        bpv_cnt_q <= bpv_cnt_q + 1'b1;
                    end
                    if (in_edge[gi]) begin
                        if (win_q == `BPV_WINDOW - 1) begin
                            win_q      <= {`BPV_CNT_W{1'b0}};
                            bpv_prev_q <= bpv_cnt_q;
                            bpv_cnt_q  <= {`BPV_CNT_W{1'b0}};
                            shift_q    <= (diff > `BPV_TOL);
                        end else begin
                            win_q <= win_q + 1'b1;
                        end
                    end
                end
            end

            // framing checked only for DS-1/DS-1C; composite needs presence
            assign in_ok[gi] = in_active[gi] & (cc_mode | ~frame_err[gi]) & ~(cc_mode & shift_q);

            // one second recognition, restarted on corruption
            qualify_timer #(
                .CNT_W      (`REC_CNT_W),
                .REC_CYCLES (REC_CYCLES)
            ) u_qual (
                .clk   (REF_CLK),
                .rst_n (rst_n),
                .ok    (in_ok[gi]),
                .good  (good[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // source selection and oscillator mode
    // ----------------------------------------
    reg       sel_q;
    reg       sel_d;
    reg [1:0] mode_q;
    reg [1:0] mode_d;
    wire      any_good = good[0] | good[1];

    always @* begin
        sel_d  = sel_q;
        mode_d = mode_q;
        case (mode_q)
            `MODE_INPUT: begin
                // dual loss picks the configured failure mode
                if (!any_good) begin
                    mode_d = holdover_cfg ? `MODE_HOLDOVER : `MODE_FREERUN;
                end
            end
            `MODE_HOLDOVER: begin
                if (any_good) begin
                    mode_d = `MODE_INPUT;
                end
            end
            `MODE_FREERUN: begin
                // restored composite input replaces factory reference
                if (any_good) begin
                    mode_d = `MODE_INPUT;
                end
            end
            default: begin
                mode_d = `MODE_INPUT;
            end
        endcase
        // single source, automatic or manual transfer to a good input
        if (good[~sel_q] && (!good[sel_q] || xfer_p)) begin
            sel_d = ~sel_q;
        end
    end

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sel_q  <= `SEL_RESET;
            mode_q <= `MODE_INPUT;
        end else begin
            sel_q  <= sel_d;
            mode_q <= mode_d;
        end
    end

    // ----------------------------------------
    // oscillator: held period and divider
    // ----------------------------------------
    reg  [`PER_W-1:0]   period_q;
    reg  [`PER_W+7:0]   div_cnt_q;
    wire [`PER_W-1:0]   sel_period = sel_q ? in_period[2*`PER_W-1:`PER_W] : in_period[`PER_W-1:0];
    wire                sel_edge   = sel_q ? in_edge[1] : in_edge[0];
    wire [`PER_W+1:0]   avg_sum    = {2'b00, period_q} + {1'b0, period_q, 1'b0} + {2'b00, sel_period};
    wire [`PER_W+7:0]   lock_half  = period_q * DIV_RATIO[7:0];
    wire [`PER_W+7:0]   target     = (mode_q == `MODE_FREERUN) ? FREE_HALF[`PER_W+7:0] : lock_half;
    wire                bypass     = cc_mode & (mode_q == `MODE_INPUT);
    reg                 tick;

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            period_q <= `PERIOD_RESET;
        end else if (sel_edge && good[sel_q] && mode_q == `MODE_INPUT) begin
            // updates stop outside input mode, so holdover keeps the last value
            // slow averaging slews the frequency, never steps the phase
            period_q <= avg_sum[`PER_W+1:2];
        end
    end

    always @* begin
        // composite clock drives the generator directly
        if (bypass) begin
            tick = sel_edge;
        end else begin
            tick = (div_cnt_q >= target - 1'b1);
        end
    end

    // divider phase carries across every mode change
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= {(`PER_W+8){1'b0}};
        end else if (tick) begin
            div_cnt_q <= {(`PER_W+8){1'b0}};
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    // ----------------------------------------
    // dual-rail generator and taps
    // ----------------------------------------
    reg out_clk_q;
    reg rail_q;

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            out_clk_q <= 1'b0;
            rail_q    <= 1'b0;
            DR_POS    <= 1'b0;
            DR_NEG    <= 1'b0;
            AUX1_POS  <= 1'b0;
            AUX1_NEG  <= 1'b0;
            AUX2_POS  <= 1'b0;
            AUX2_NEG  <= 1'b0;
        end else begin
            if (tick) begin
                out_clk_q <= ~out_clk_q;
                if (out_clk_q) begin
                    rail_q <= ~rail_q;
                end
            end
            DR_POS   <= out_clk_q & ~rail_q;
            DR_NEG   <= out_clk_q & rail_q;
            // independent tap pair per auxiliary panel
            AUX1_POS <= out_clk_q & ~rail_q;
            AUX1_NEG <= out_clk_q & rail_q;
            AUX2_POS <= out_clk_q & ~rail_q;
            AUX2_NEG <= out_clk_q & rail_q;
        end
    end

    // ----------------------------------------
    // configuration and status outputs
    // ----------------------------------------
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            LIU_DS1C           <= 1'b0;
            LIU_ESF            <= 1'b0;
            LIU_B8ZS           <= 1'b0;
            LIU_SECOND_DIGROUP <= 1'b0;
            SOURCE_IS_B        <= `SEL_RESET;
            MODE_STATUS        <= `MODE_INPUT;
            ALARM_IN_FAIL_A    <= 1'b0;
            ALARM_IN_FAIL_B    <= 1'b0;
            ALARM_DUAL_FAIL    <= 1'b0;
        end else begin
            LIU_DS1C           <= opt_q[`OPT_TYPE_BIT];
            LIU_ESF            <= opt_q[`OPT_FRAMING_BIT];
            LIU_B8ZS           <= opt_q[`OPT_CODING_BIT];
            LIU_SECOND_DIGROUP <= opt_q[`OPT_DIGROUP_BIT];
            SOURCE_IS_B        <= sel_q;
            MODE_STATUS        <= mode_q;
            ALARM_IN_FAIL_A    <= ~good[0];
            ALARM_IN_FAIL_B    <= ~good[1];
            ALARM_DUAL_FAIL    <= (mode_q != `MODE_INPUT);
        end
    end

endmodule

// file: verilog/timing_sel_regs.vh
`ifndef TIMING_SEL_REGS_VH
`define TIMING_SEL_REGS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_FREQ_HZ       200000000
`define REC_TIME_MS       1000
`define REC_CYCLES        ((`CLK_FREQ_HZ / 1000) * `REC_TIME_MS)
`define REC_CNT_W         28
`define LOS_CYCLES        64
`define PER_W             16
`define DIV_RATIO         12
`define FREE_HALF_PERIOD  1563
`define BPV_WINDOW        1024
`define BPV_TOL           4
`define BPV_CNT_W         11

// ----------------------------------------
// input option switch bit positions
// ----------------------------------------
`define OPT_TYPE_BIT      0
`define OPT_FRAMING_BIT   1
`define OPT_CODING_BIT    2
`define OPT_DIGROUP_BIT   3

// ----------------------------------------
// oscillator modes
// ----------------------------------------
`define MODE_INPUT        2'h0
`define MODE_HOLDOVER     2'h1
`define MODE_FREERUN      2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define PERIOD_RESET      16'h0020
`define SEL_RESET         1'b0

`endif

// file: verilog/edge_monitor.v
`timescale 1ns/1ps
`include "timing_sel_regs.vh"

module edge_monitor #(
    parameter PER_W      = `PER_W,
    parameter LOS_CYCLES = `LOS_CYCLES
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // link clock pin
    input  wire             link_in,
    // detected activity
    output reg              edge_p,
    output reg              active,
    output reg  [PER_W-1:0] period
);

    reg             s1_q;
    reg             s2_q;
    reg             s3_q;
    reg [PER_W-1:0] cnt_q;

    wire rise = s2_q & ~s3_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            cnt_q  <= {PER_W{1'b0}};
            edge_p <= 1'b0;
            active <= 1'b0;
            period <= `PERIOD_RESET;
        end else begin
            s1_q   <= link_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            edge_p <= rise;
            if (rise) begin
                period <= cnt_q + 1'b1;
                cnt_q  <= {PER_W{1'b0}};
                active <= 1'b1;
            end else if (cnt_q == LOS_CYCLES[PER_W-1:0] - 1'b1) begin
                // continuity lost: no edge within the window
                active <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule

// file: verilog/qualify_timer.v
`timescale 1ns/1ps
`include "timing_sel_regs.vh"

module qualify_timer #(
    parameter CNT_W      = `REC_CNT_W,
    parameter REC_CYCLES = `REC_CYCLES
) (
    // clock and reset
    input  wire clk,
    input  wire rst_n,
    // raw health and qualified result
    input  wire ok,
    output reg  good
);

    reg [CNT_W-1:0] cnt_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {CNT_W{1'b0}};
            good  <= 1'b0;
        end else if (!ok) begin
            // any corruption restarts the whole recognition wait
            cnt_q <= {CNT_W{1'b0}};
            good  <= 1'b0;
        end else if (!good) begin
            if (cnt_q == REC_CYCLES[CNT_W-1:0] - 1'b1) begin
                good <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule

// file: test/timing_sel_props.sv
`timescale 1ns/1ps
`include "timing_sel_regs.vh"
module timing_sel_props (
    // clock and reset
    input wire       REF_CLK,
    input wire       RESET_N,
    // switches
    input wire [3:0] INPUT_OPTION_SWITCH,
    input wire       FAILOVER_MODE_SWITCH,
    // watched outputs
    input wire       LIU_DS1C,
    input wire       LIU_ESF,
    input wire       LIU_B8ZS,
    input wire       LIU_SECOND_DIGROUP,
    input wire       DR_POS,
    input wire       DR_NEG,
    input wire       AUX1_POS,
    input wire       AUX1_NEG,
    input wire       AUX2_POS,
    input wire       AUX2_NEG,
    input wire       SOURCE_IS_B,
    input wire [1:0] MODE_STATUS,
    input wire       ALARM_IN_FAIL_A,
    input wire       ALARM_IN_FAIL_B,
    input wire       ALARM_DUAL_FAIL
);
    // ----------------------------------------
    // settle counter
    // ----------------------------------------
    // internal reset trails the pin, so option copies are judged late
    reg  [3:0] up_q;
    wire [3:0] up_d;
    wire [3:0] liu;
    wire       both_bad;
    assign up_d = (up_q == 4'hF) ? up_q : up_q + 4'h1;
    assign liu = {LIU_SECOND_DIGROUP, LIU_B8ZS, LIU_ESF, LIU_DS1C};
    assign both_bad = ALARM_IN_FAIL_A && ALARM_IN_FAIL_B;
    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            up_q <= 4'h0;
        end else begin
            up_q <= up_d;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    a_option_copy: assert property (
        ((up_q == 4'hF) && $stable(INPUT_OPTION_SWITCH)) [*6] |-> liu == INPUT_OPTION_SWITCH)
        else $error("option outputs differ from switches");
    a_mode_chosen: assert property (
        $past(MODE_STATUS) == `MODE_INPUT && MODE_STATUS != `MODE_INPUT
        |-> MODE_STATUS == (FAILOVER_MODE_SWITCH ? `MODE_HOLDOVER : `MODE_FREERUN))
        else $error("dual failure mode does not match switch");
    a_dual_entry: assert property (
        both_bad [*5] |-> MODE_STATUS != `MODE_INPUT)
        else $error("both inputs bad but mode stays input");
    a_restore_exit: assert property (
        !both_bad |-> ##[0:3] MODE_STATUS == `MODE_INPUT)
        else $error("good input present but mode not input");
    a_dual_alarm: assert property (
        (MODE_STATUS != `MODE_INPUT) [*2] |-> ALARM_DUAL_FAIL)
        else $error("dual alarm missing");
    a_dual_clear: assert property (
        (MODE_STATUS == `MODE_INPUT) [*2] |-> !ALARM_DUAL_FAIL)
        else $error("dual alarm stuck");
    a_auto_to_b: assert property (
        ALARM_IN_FAIL_A && !ALARM_IN_FAIL_B && !SOURCE_IS_B |-> ##[1:4] SOURCE_IS_B)
        else $error("no move to input b");
    a_auto_to_a: assert property (
        ALARM_IN_FAIL_B && !ALARM_IN_FAIL_A && SOURCE_IS_B |-> ##[1:4] !SOURCE_IS_B)
        else $error("no move to input a");
    a_source_good: assert property (
        $changed(SOURCE_IS_B) |-> (SOURCE_IS_B ? !ALARM_IN_FAIL_B : !ALARM_IN_FAIL_A))
        else $error("selection moved to a bad input");
    a_tap_copy: assert property (
        {AUX1_POS, AUX1_NEG, AUX2_POS, AUX2_NEG} == {2{DR_POS, DR_NEG}})
        else $error("taps differ from main pair");
    a_rails_apart: assert property (
        !(DR_POS && DR_NEG))
        else $error("both rails high");
endmodule

bind timing_reference_selector timing_sel_props props (
    .REF_CLK, .RESET_N, .INPUT_OPTION_SWITCH, .FAILOVER_MODE_SWITCH,
    .LIU_DS1C, .LIU_ESF, .LIU_B8ZS, .LIU_SECOND_DIGROUP, .DR_POS, .DR_NEG,
    .AUX1_POS, .AUX1_NEG, .AUX2_POS, .AUX2_NEG, .SOURCE_IS_B, .MODE_STATUS,
    .ALARM_IN_FAIL_A, .ALARM_IN_FAIL_B, .ALARM_DUAL_FAIL
);

// file: test/ref_source_model.sv
`timescale 1ns/1ps
module ref_source_model #(
    parameter real START_NS = 3.0
) (
    // control from bench
    input  wire       en,
    input  wire       frame_bad,
    input  wire [7:0] bpv_every,
    // reference line
    output reg        line_clk,
    output wire       frame_err,
    output reg        bpv
);
    integer n;
    assign frame_err = frame_bad;
    // a lost line stands still low, as a dead reference would
    initial begin
        line_clk = 1'b0;
        bpv = 1'b0;
        n = 0;
        #(START_NS);
        forever begin
            #40.0;
            line_clk = en & ~line_clk;
            n = n + line_clk;
            bpv = line_clk && (bpv_every != 8'h00) && (n % bpv_every == 0);
        end
    end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
`include "timing_sel_regs.vh"
`define CHECK(got, exp) begin \
    comparisons = comparisons + 1; \
    if ((got) !== (exp)) begin \
        fails = fails + 1; \
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
module testbench;
    localparam REC  = 200;
    localparam FREE = 40;
    reg         REF_CLK, RESET_N, mode_sw, cc_sel, xfer_n;
    reg         en_a, en_b, bad_a, bad_b;
    reg  [3:0]  opt_sw;
    reg  [7:0]  bpv_a, bpv_b;
    reg  [31:0] seed;
    wire        clk_a, clk_b, fe_a, fe_b, pv_a, pv_b;
    wire        dr_pos, dr_neg, src_b, fail_a, fail_b, dual;
    wire [3:0]  liu, aux;
    wire [1:0]  mode;
    integer     fails, comparisons, i, k;

    ref_source_model #(.START_NS(3.3)) ref_a (.en(en_a), .frame_bad(bad_a), .bpv_every(bpv_a),
        .line_clk(clk_a), .frame_err(fe_a), .bpv(pv_a));
    ref_source_model #(.START_NS(17.9)) ref_b (.en(en_b), .frame_bad(bad_b), .bpv_every(bpv_b),
        .line_clk(clk_b), .frame_err(fe_b), .bpv(pv_b));
    // short recognition time keeps the run small
    timing_reference_selector #(.REC_CYCLES(REC), .FREE_HALF(FREE)) uut (
        .REF_CLK(REF_CLK), .RESET_N(RESET_N), .IN_A_CLK(clk_a), .IN_B_CLK(clk_b),
        .IN_A_FRAME_ERR(fe_a), .IN_B_FRAME_ERR(fe_b), .IN_A_BPV(pv_a), .IN_B_BPV(pv_b),
        .INPUT_OPTION_SWITCH(opt_sw), .FAILOVER_MODE_SWITCH(mode_sw),
        .COMPOSITE_CLOCK_INPUT(cc_sel), .TRANSFER_REQ_N(xfer_n),
        .LIU_DS1C(liu[0]), .LIU_ESF(liu[1]), .LIU_B8ZS(liu[2]), .LIU_SECOND_DIGROUP(liu[3]),
        .DR_POS(dr_pos), .DR_NEG(dr_neg), .AUX1_POS(aux[0]), .AUX1_NEG(aux[1]),
        .AUX2_POS(aux[2]), .AUX2_NEG(aux[3]), .SOURCE_IS_B(src_b), .MODE_STATUS(mode),
        .ALARM_IN_FAIL_A(fail_a), .ALARM_IN_FAIL_B(fail_b), .ALARM_DUAL_FAIL(dual));

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [1:0] fail_mode(input sw);
        fail_mode = sw ? `MODE_HOLDOVER : `MODE_FREERUN;
    endfunction
    // one rail pulse per two generator toggles, half clocks apart
    function integer rail_pulses(input integer n, input integer half);
        rail_pulses = n / (2 * half);
    endfunction

    task summarize;
        begin
            $display("comparisons=%0d fails=%0d", comparisons, fails);
            if (fails == 0 && comparisons > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    task cycles(input integer n);
        repeat (n) @(negedge REF_CLK);
    endtask
    task wait_mode(input [1:0] m, input integer bound);
        integer w;
        begin
            w = 0;
            while (mode !== m && w < bound) begin
                @(negedge REF_CLK);
                w = w + 1;
            end
            `CHECK(mode, m)
            if (mode !== m) summarize;
        end
    endtask
    task press;
        begin
            xfer_n = 1'b0;
            cycles(4);
            xfer_n = 1'b1;
            cycles(8);
        end
    endtask
    task count_rails(input integer n, output integer c);
        reg     p;
        integer j;
        begin
            c = 0;
            p = dr_pos | dr_neg;
            for (j = 0; j < n; j = j + 1) begin
                @(negedge REF_CLK);
                c = c + ((dr_pos | dr_neg) & !p);
                p = dr_pos | dr_neg;
            end
        end
    endtask

    initial begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    initial begin
        #450000;
        fails = fails + 1;
        summarize;
    end
    initial begin
        fails = 0;
        comparisons = 0;
        seed = 32'h7453;
        RESET_N = 1'b0;
        {mode_sw, cc_sel, en_a, en_b, bad_a, bad_b} = 6'h00;
        xfer_n = 1'b1;
        opt_sw = 4'h0;
        bpv_a = 8'h00;
        bpv_b = 8'h00;
        cycles(3);
        `CHECK({src_b, mode, dual}, 4'h0)
        RESET_N = 1'b1;
        wait_mode(fail_mode(mode_sw), 50);
        `CHECK({fail_a, fail_b, dual}, 3'h7)
        for (i = 0; i < 16; i = i + 1) begin
            seed = xs(seed);
            opt_sw = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : seed[3:0];
            cycles(8);
            `CHECK(liu, opt_sw)
        end
        opt_sw = 4'h2;
        en_a = 1'b1;
        cycles(REC - 60);
        `CHECK(fail_a, 1'b1)
        bad_a = 1'b1;
        cycles(1 + seed[2:0]);
        bad_a = 1'b0;
        cycles(REC - 40);
        `CHECK(fail_a, 1'b1)
        wait_mode(`MODE_INPUT, 120);
        `CHECK({fail_a, src_b}, 2'b00)
        en_b = 1'b1;
        cycles(REC + 40);
        `CHECK(fail_b, 1'b0)
        press;
        `CHECK(src_b, 1'b1)
        en_b = 1'b0;
        cycles(110);
        `CHECK({fail_b, src_b, mode}, 4'h8)
        press;
        `CHECK(src_b, 1'b0)
        mode_sw = 1'b1;
        cycles(4);
        en_a = 1'b0;
        wait_mode(fail_mode(mode_sw), 150);
        `CHECK({fail_a, dual}, 2'b11)
        count_rails(600, k);
        `CHECK(k > 0, 1'b1)
        en_b = 1'b1;
        wait_mode(`MODE_INPUT, REC + 100);
        cycles(4);
        `CHECK(src_b, 1'b1)
        cc_sel = 1'b1;
        mode_sw = 1'b0;
        cycles(8);
        // framing errors mean nothing to a composite clock line
        bad_a = 1'b1;
        bad_b = 1'b1;
        en_a = 1'b1;
        cycles(REC + 60);
        `CHECK({fail_a, fail_b, mode}, 4'h0)
        count_rails(512, k);
        `CHECK(k >= rail_pulses(512, 16) - 1 && k <= rail_pulses(512, 16) + 1, 1'b1)
        // a density step shows at the end of a 1024-edge window
        bpv_a = 8'h10;
        k = 0;
        while (fail_a !== 1'b1 && k < 36000) begin
            @(negedge REF_CLK);
            k = k + 1;
        end
        `CHECK(fail_a, 1'b1)
        if (fail_a !== 1'b1) summarize;
        en_a = 1'b0;
        en_b = 1'b0;
        wait_mode(`MODE_FREERUN, 200);
        `CHECK({fail_a, fail_b, dual}, 3'h7)
        count_rails(800, k);
        `CHECK(k >= rail_pulses(800, FREE) - 1 && k <= rail_pulses(800, FREE) + 1, 1'b1)
        en_b = 1'b1;
        wait_mode(`MODE_INPUT, REC + 100);
        `CHECK({dual, src_b}, 2'b01)
        summarize;
    end
endmodule
